//--- src/hgr_pkg.sv
package hgr_pkg;
  localparam int NPIN = 10;
  localparam int NBUF = 12;
  // apb byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_DATA0 = 12'h004;
  localparam logic [11:0] ADDR_DATA1 = 12'h008;
  localparam logic [11:0] ADDR_DATA2 = 12'h00C;
  localparam int CTRL_SET_BIT = 8;
  localparam int CTRL_ERR_BIT = 16;
  // report identifiers
  localparam logic [7:0] ID_STATE_GET = 8'h44;
  localparam logic [7:0] ID_STATE_SET = 8'h45;
  localparam logic [7:0] ID_VERSION = 8'h46;
  localparam logic [7:0] ID_LOCK = 8'h47;
  localparam logic [7:0] ID_XFER = 8'h48;
  localparam logic [7:0] ID_CFG = 8'h49;
  // lock word: unprogrammed value and writable bits
  localparam logic [15:0] LOCK_RESET = 16'hFF8F;
  localparam logic [15:0] LOCK_VALID = 16'hFF8F;
  // transfer mode reset values
  localparam logic TX_WIDE_RESET = 1'b0;
  localparam logic RX_WIDE_RESET = 1'b0;
  localparam logic LOW_LAT_RESET = 1'b1;
  // mode byte fields
  localparam logic [7:0] MODE0_VALID = 8'h7F;
  localparam logic [7:0] MODE1_VALID = 8'hC1;
  localparam int MODE0_POL = 3;
  localparam int MODE0_DE_PIN = 4;
  localparam int MODE0_DE_SEL = 5;
  localparam int MODE1_CLK_EN = 0;
  localparam int MODE1_TXT_EN = 6;
  localparam int MODE1_RXT_EN = 7;
  localparam logic [2:0] MODEM_RTS_CTS = 3'h1;
  localparam logic [2:0] MODEM_DTR_DSR = 3'h2;
  localparam logic [2:0] MODEM_DE_TX = 3'h3;
  localparam logic [2:0] MODEM_DE_ADDR = 3'h4;
  localparam logic [1:0] DE_SEL_GPIO = 2'h0;
  localparam logic [1:0] DE_SEL_RSVD = 2'h3;
  // timing
  localparam int CORE_CLK_HZ = 40000000;
  localparam int OUT_CLK_HZ = 24000000;
  localparam int TICK_MOD = CORE_CLK_HZ / 1000000;
  localparam int TICK_INC = OUT_CLK_HZ / 1000000;

  typedef struct packed {
    logic [NPIN-1:0] dir;
    logic [NPIN-1:0] push_pull;
    logic [NPIN-1:0] pull_up;
    logic [NPIN-1:0] pull_dn;
    logic [7:0] clk_hi;
    logic [7:0] clk_lo;
    logic [7:0] mode0;
    logic [7:0] mode1;
  } hgr_cfg_s;

  typedef struct packed {
    logic rts_n;
    logic dtr_n;
    logic tx_active;
    logic tx_toggle;
    logic rx_toggle;
    logic rx_level;
    logic tx_level;
  } hgr_uart_s;

  function automatic logic [NPIN-1:0] hgr_unpack(input logic [15:0] w);
    return {w[13:10], w[7:6], w[3:0]};
  endfunction

  function automatic logic [15:0] hgr_pack(input logic [NPIN-1:0] p);
    return {2'b00, p[9:6], 2'b00, p[5:4], 2'b00, p[3:0]};
  endfunction
endpackage

//--- src/hgr_pin_cell.sv
`timescale 1ns/1ps
module hgr_pin_cell (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic gp_out,
  input wire logic dir,
  input wire logic push_pull,
  input wire logic pull_up,
  input wire logic pull_dn,
  input wire logic special_en,
  input wire logic special_drv,
  input wire logic special_val,
  output logic pad_out,
  output logic pad_oe_n,
  output logic pad_pu,
  output logic pad_pd
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out <= 1'b0;
      pad_oe_n <= 1'b1;
      pad_pu <= 1'b0;
      pad_pd <= 1'b0;
    end else if (special_en) begin
      // RULE_17 special ignores config
      pad_out <= special_val;
      pad_oe_n <= ~special_drv;
      pad_pu <= 1'b0;
      pad_pd <= 1'b0;
    end else if (dir) begin
      // RULE_12 RULE_13 output drive
      pad_out <= push_pull ? gp_out : 1'b0;
      pad_oe_n <= push_pull ? 1'b0 : gp_out;
      pad_pu <= 1'b0;
      pad_pd <= 1'b0;
    end else begin
      // RULE_14 RULE_15 input pulls
      pad_out <= 1'b0;
      pad_oe_n <= 1'b1;
      pad_pu <= pull_up;
      pad_pd <= pull_dn & ~pull_up;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pull_excl;
    pad_pu |-> !pad_pd;
  endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("both pulls on"); // RULE_15
  property p_od_low;
    !special_en && dir && !push_pull && !gp_out |=> !pad_oe_n && !pad_out;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain not driving low"); // RULE_13
endmodule // hgr_pin_cell

//--- src/hgr_clk_div.sv
`timescale 1ns/1ps
module hgr_clk_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [7:0] hi_period,
  input wire logic [7:0] lo_period,
  output logic clk_level
);
  logic [5:0] acc_q;
  logic tick_q;
  logic [7:0] cnt_q;
  logic lvl_q;
  logic [7:0] limit;
  logic both_zero;

  // fractional 24 MHz tick enable from the core clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= 6'h00;
      tick_q <= 1'b0;
    end else if (acc_q + 6'(hgr_pkg::TICK_INC) >= 6'(hgr_pkg::TICK_MOD)) begin
      acc_q <= acc_q + 6'(hgr_pkg::TICK_INC) - 6'(hgr_pkg::TICK_MOD);
      tick_q <= 1'b1;
    end else begin
      acc_q <= acc_q + 6'(hgr_pkg::TICK_INC);
      tick_q <= 1'b0;
    end
  end

  assign limit = lvl_q ? hi_period : lo_period;
  assign both_zero = (hi_period == 8'h00) && (lo_period == 8'h00);

  // RULE_21 low then high period count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      lvl_q <= 1'b0;
    end else if (!enable) begin
      cnt_q <= 8'h00;
      lvl_q <= 1'b0;
    end else if (both_zero) begin
      cnt_q <= 8'h00;
      lvl_q <= tick_q;
    end else if (tick_q) begin
      if (cnt_q + 8'h01 >= limit) begin
        cnt_q <= 8'h00;
        lvl_q <= ~lvl_q;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  assign clk_level = lvl_q;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_half;
    enable && hi_period == 8'h01 && lo_period == 8'h01 && tick_q && $stable(hi_period)
      |=> lvl_q != $past(lvl_q);
  endproperty
  a_half: assert property (p_half) else $error("divide by two not toggling"); // RULE_21
endmodule // hgr_clk_div

//--- src/hgr_report_handler.sv
// Summary of operation
// RULE_01 - get pin state 0x44 returns live 16-bit pin word, high byte first
// RULE_02 - live word carries status pins, uart rx/tx and ten general pins
// RULE_03 - set state 0x45 drives masked bits onto output pins only
// RULE_04 - reserved bits of state and mask words are ignored
// RULE_05 - version 0x46 returns product id low byte and silicon revision
// RULE_06 - report 0x47 reads or writes the 16-bit lock word
// RULE_07 - thirteen lock fields; zero locks a field, all zeros locks all
// RULE_08 - a locked field never unlocks; presetn reloads LOCK_RESET, reopening all fields
// RULE_09 - report 0x48 byte 1 bit 0 is transmit wide, reset off
// RULE_10 - byte 2 bit 0 receive wide off, bit 1 low latency on
// RULE_11 - report 0x49 carries four config words then four bytes
// RULE_12 - direction bit 0 input, 1 output
// RULE_13 - drive bit 0 open drain, 1 push-pull
// RULE_14 - pull-up bit 1 enables weak pull-up on inputs
// RULE_15 - pull-down only when pull-up is off
// RULE_16 - config takes effect at once and is lost at reset
// RULE_17 - special function pins ignore direction, drive and pull settings
// RULE_18 - bytes 9 and 10 are clock high and low periods
// RULE_19 - byte 11 is half-duplex control, byte 12 clock and toggle
// RULE_20 - pins start from stored config; readback need not match
// RULE_21 - clock is 24 MHz over high plus low, 24 MHz if both zero
// RULE_22 - clock output only when mode byte two bit 0 is set
// RULE_23 - config words use the state word bit map
// RULE_24 - reserved bits read zero and ignore writes
`timescale 1ns/1ps
module hgr_report_handler #(
  parameter logic [7:0] PID_LSB = 8'h5A, // arbitrary value
  parameter logic [7:0] SILICON_REV = 8'h01 // arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire hgr_pkg::hgr_cfg_s stored_cfg,
  input wire hgr_pkg::hgr_uart_s uart_in,
  input wire logic usb_status_pin_one,
  input wire logic usb_status_pin_two,
  input wire logic [hgr_pkg::NPIN-1:0] pin_in,
  output logic [hgr_pkg::NPIN-1:0] pin_out,
  output logic [hgr_pkg::NPIN-1:0] pin_oe_n,
  output logic [hgr_pkg::NPIN-1:0] pin_pull_up,
  output logic [hgr_pkg::NPIN-1:0] pin_pull_dn,
  output logic pin2_clear_to_send,
  output logic pin9_set_ready,
  output logic tx_wide,
  output logic rx_wide,
  output logic low_latency,
  output logic [15:0] otp_lock
);
  localparam int N = hgr_pkg::NPIN;

  logic [7:0] buf_q [hgr_pkg::NBUF];
  hgr_pkg::hgr_cfg_s cfg_q;
  hgr_pkg::hgr_cfg_s eff;
  logic cfg_dyn_q;
  logic [N-1:0] gp_out_q;
  logic [15:0] lock_q;
  logic tx_wide_q;
  logic rx_wide_q;
  logic low_lat_q;
  logic [7:0] last_id_q;
  logic err_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic mapped;
  logic access;
  logic exec;
  logic is_set;
  logic [7:0] rep_id;
  logic id_ok;
  logic [15:0] live;
  logic [N-1:0] st_bits;
  logic [N-1:0] mk_bits;
  logic [N-1:0] sp_en;
  logic [N-1:0] sp_drv;
  logic [N-1:0] sp_val;
  logic [2:0] modem_sel;
  logic [1:0] de_sel;
  logic de_level;
  logic clk_level;

  // apb decode
  assign access = psel & penable;
  assign mapped = (paddr == hgr_pkg::ADDR_CTRL) || (paddr == hgr_pkg::ADDR_DATA0) ||
                  (paddr == hgr_pkg::ADDR_DATA1) || (paddr == hgr_pkg::ADDR_DATA2);
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign exec = access & pwrite & (paddr == hgr_pkg::ADDR_CTRL) & pstrb[0];
  assign rep_id = pwdata[7:0];
  assign is_set = pwdata[hgr_pkg::CTRL_SET_BIT];

  always_comb begin
    case (rep_id)
      hgr_pkg::ID_STATE_GET: id_ok = ~is_set;
      hgr_pkg::ID_STATE_SET: id_ok = is_set;
      hgr_pkg::ID_VERSION: id_ok = ~is_set;
      hgr_pkg::ID_LOCK: id_ok = 1'b1;
      hgr_pkg::ID_XFER: id_ok = 1'b1;
      hgr_pkg::ID_CFG: id_ok = 1'b1;
      default: id_ok = 1'b0;
    endcase
  end

  // RULE_02 live pin level word
  assign live = {1'b0, usb_status_pin_one, pin_in[9:6], 1'b0, usb_status_pin_two,
                 pin_in[5:4], uart_in.rx_level, uart_in.tx_level, pin_in[3:0]};

  // RULE_04 reserved state bits dropped
  assign st_bits = hgr_pkg::hgr_unpack({buf_q[0], buf_q[1]});
  assign mk_bits = hgr_pkg::hgr_unpack({buf_q[2], buf_q[3]});

  // RULE_20 stored config until first dynamic write
  assign eff = cfg_dyn_q ? cfg_q : stored_cfg;

  always_comb begin
    case (paddr)
      hgr_pkg::ADDR_CTRL: rd_mux = {15'h0000, err_q, 8'h00, last_id_q};
      hgr_pkg::ADDR_DATA0: rd_mux = {buf_q[3], buf_q[2], buf_q[1], buf_q[0]};
      hgr_pkg::ADDR_DATA1: rd_mux = {buf_q[7], buf_q[6], buf_q[5], buf_q[4]};
      hgr_pkg::ADDR_DATA2: rd_mux = {buf_q[11], buf_q[10], buf_q[9], buf_q[8]};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // read data captured in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_q <= rd_mux;
    end
  end
  assign prdata = prdata_q;

  // report status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_id_q <= 8'h00;
      err_q <= 1'b0;
    end else if (exec) begin
      last_id_q <= rep_id;
      err_q <= ~id_ok;
    end
  end

  // report data buffer: host writes, get reports fill
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < hgr_pkg::NBUF; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else if (exec && id_ok && !is_set) begin
      for (int i = 0; i < hgr_pkg::NBUF; i++) begin
        buf_q[i] <= 8'h00;
      end
      case (rep_id)
        hgr_pkg::ID_STATE_GET: begin
          // RULE_01 live word high byte first
          buf_q[0] <= live[15:8];
          buf_q[1] <= live[7:0];
        end
        hgr_pkg::ID_VERSION: begin
          // RULE_05 product and revision
          buf_q[0] <= PID_LSB;
          buf_q[1] <= SILICON_REV;
        end
        hgr_pkg::ID_LOCK: begin
          // RULE_06 lock word readback
          buf_q[0] <= lock_q[15:8];
          buf_q[1] <= lock_q[7:0];
        end
        hgr_pkg::ID_XFER: begin
          // RULE_10 RULE_24 mode readback
          buf_q[0] <= {7'h00, tx_wide_q};
          buf_q[1] <= {6'h00, low_lat_q, rx_wide_q};
        end
        hgr_pkg::ID_CFG: begin
          // RULE_11 RULE_23 config readback
          {buf_q[0], buf_q[1]} <= hgr_pkg::hgr_pack(cfg_q.dir);
          {buf_q[2], buf_q[3]} <= hgr_pkg::hgr_pack(cfg_q.push_pull);
          {buf_q[4], buf_q[5]} <= hgr_pkg::hgr_pack(cfg_q.pull_up);
          {buf_q[6], buf_q[7]} <= hgr_pkg::hgr_pack(cfg_q.pull_dn);
          buf_q[8] <= cfg_q.clk_hi;
          buf_q[9] <= cfg_q.clk_lo;
          buf_q[10] <= cfg_q.mode0;
          buf_q[11] <= cfg_q.mode1;
        end
        default: begin
        end
      endcase
    end else if (access && pwrite) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b] && paddr == hgr_pkg::ADDR_DATA0) begin
          buf_q[b] <= pwdata[8*b +: 8];
        end
        if (pstrb[b] && paddr == hgr_pkg::ADDR_DATA1) begin
          buf_q[4+b] <= pwdata[8*b +: 8];
        end
        if (pstrb[b] && paddr == hgr_pkg::ADDR_DATA2) begin
          buf_q[8+b] <= pwdata[8*b +: 8];
        end
      end
    end
  end

  // RULE_03 masked output state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp_out_q <= '0;
    end else if (exec && is_set && rep_id == hgr_pkg::ID_STATE_SET) begin
      gp_out_q <= (gp_out_q & ~(mk_bits & eff.dir)) | (st_bits & mk_bits & eff.dir);
    end
  end

  // RULE_07 RULE_08 lock bits only clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= hgr_pkg::LOCK_RESET;
    end else if (exec && is_set && rep_id == hgr_pkg::ID_LOCK) begin
      lock_q <= lock_q & {buf_q[0], buf_q[1]} & hgr_pkg::LOCK_VALID;
    end
  end

  // RULE_09 RULE_10 transfer mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wide_q <= hgr_pkg::TX_WIDE_RESET;
      rx_wide_q <= hgr_pkg::RX_WIDE_RESET;
      low_lat_q <= hgr_pkg::LOW_LAT_RESET;
    end else if (exec && is_set && rep_id == hgr_pkg::ID_XFER) begin
      tx_wide_q <= buf_q[0][0];
      rx_wide_q <= buf_q[1][0];
      low_lat_q <= buf_q[1][1];
    end
  end

  // RULE_16 RULE_11 RULE_18 RULE_19 volatile config
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '0;
      cfg_dyn_q <= 1'b0;
    end else if (exec && is_set && rep_id == hgr_pkg::ID_CFG) begin
      cfg_q.dir <= hgr_pkg::hgr_unpack({buf_q[0], buf_q[1]});
      cfg_q.push_pull <= hgr_pkg::hgr_unpack({buf_q[2], buf_q[3]});
      cfg_q.pull_up <= hgr_pkg::hgr_unpack({buf_q[4], buf_q[5]});
      cfg_q.pull_dn <= hgr_pkg::hgr_unpack({buf_q[6], buf_q[7]});
      cfg_q.clk_hi <= buf_q[8];
      cfg_q.clk_lo <= buf_q[9];
      // RULE_24 reserved mode bits dropped
      cfg_q.mode0 <= buf_q[10] & hgr_pkg::MODE0_VALID;
      cfg_q.mode1 <= buf_q[11] & hgr_pkg::MODE1_VALID;
      cfg_dyn_q <= 1'b1;
    end
  end

  // special function selection
  assign modem_sel = eff.mode0[2:0];
  assign de_sel = eff.mode0[hgr_pkg::MODE0_DE_SEL +: 2];
  assign de_level = uart_in.tx_active ~^ eff.mode0[hgr_pkg::MODE0_POL];

  always_comb begin
    sp_en = '0;
    sp_drv = '0;
    sp_val = '0;
    // RULE_22 clock output gate
    sp_en[0] = eff.mode1[hgr_pkg::MODE1_CLK_EN];
    sp_drv[0] = 1'b1;
    sp_val[0] = clk_level;
    if (modem_sel == hgr_pkg::MODEM_RTS_CTS) begin
      sp_en[1] = 1'b1;
      sp_drv[1] = 1'b1;
      sp_val[1] = uart_in.rts_n;
      sp_en[2] = 1'b1;
    end else if (!eff.mode0[hgr_pkg::MODE0_DE_PIN] &&
                 (modem_sel == hgr_pkg::MODEM_DE_TX || modem_sel == hgr_pkg::MODEM_DE_ADDR)) begin
      sp_en[1] = 1'b1;
      sp_drv[1] = 1'b1;
      sp_val[1] = de_level;
    end
    // RULE_19 half-duplex enable pin
    if (eff.mode0[hgr_pkg::MODE0_DE_PIN] && de_sel != hgr_pkg::DE_SEL_GPIO &&
        de_sel != hgr_pkg::DE_SEL_RSVD) begin
      sp_en[3] = 1'b1;
      sp_drv[3] = 1'b1;
      sp_val[3] = de_level;
    end
    sp_en[4] = eff.mode1[hgr_pkg::MODE1_TXT_EN];
    sp_drv[4] = 1'b1;
    sp_val[4] = uart_in.tx_toggle;
    sp_en[5] = eff.mode1[hgr_pkg::MODE1_RXT_EN];
    sp_drv[5] = 1'b1;
    sp_val[5] = uart_in.rx_toggle;
    if (modem_sel == hgr_pkg::MODEM_DTR_DSR) begin
      sp_en[8] = 1'b1;
      sp_drv[8] = 1'b1;
      sp_val[8] = uart_in.dtr_n;
      sp_en[9] = 1'b1;
    end
  end

  // RULE_18 RULE_21 clock on general pin 0
  hgr_clk_div u_clk_div (
    .pclk(pclk),
    .presetn(presetn),
    .enable(eff.mode1[hgr_pkg::MODE1_CLK_EN]),
    .hi_period(eff.clk_hi),
    .lo_period(eff.clk_lo),
    .clk_level(clk_level)
  );

  for (genvar g = 0; g < N; g++) begin : g_pin
    hgr_pin_cell u_cell (
      .pclk(pclk),
      .presetn(presetn),
      .gp_out(gp_out_q[g]),
      .dir(eff.dir[g]),
      .push_pull(eff.push_pull[g]),
      .pull_up(eff.pull_up[g]),
      .pull_dn(eff.pull_dn[g]),
      .special_en(sp_en[g]),
      .special_drv(sp_drv[g]),
      .special_val(sp_val[g]),
      .pad_out(pin_out[g]),
      .pad_oe_n(pin_oe_n[g]),
      .pad_pu(pin_pull_up[g]),
      .pad_pd(pin_pull_dn[g])
    );
  end

  assign pin2_clear_to_send = pin_in[2];
  assign pin9_set_ready = pin_in[9];
  assign tx_wide = tx_wide_q;
  assign rx_wide = rx_wide_q;
  assign low_latency = low_lat_q;
  assign otp_lock = lock_q;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_get(logic [7:0] id);
    exec && !is_set && rep_id == id;
  endsequence
  sequence s_set(logic [7:0] id);
    exec && is_set && rep_id == id;
  endsequence

  property p_state_get;
    s_get(hgr_pkg::ID_STATE_GET) |=> {buf_q[0], buf_q[1]} == $past(live);
  endproperty
  a_state_get: assert property (p_state_get) else $error("pin state readback wrong"); // RULE_01
  property p_rsvd_live;
    s_get(hgr_pkg::ID_STATE_GET) |=> !buf_q[0][7] && !buf_q[0][1];
  endproperty
  a_rsvd_live: assert property (p_rsvd_live) else $error("reserved state bit set"); // RULE_02
  property p_state_set;
    s_set(hgr_pkg::ID_STATE_SET) |=>
      ((gp_out_q ^ $past(gp_out_q)) & ~$past(mk_bits & eff.dir)) == '0;
  endproperty
  a_state_set: assert property (p_state_set) else $error("unmasked pin changed"); // RULE_03
  property p_version;
    s_get(hgr_pkg::ID_VERSION) |=> buf_q[0] == PID_LSB && buf_q[1] == SILICON_REV;
  endproperty
  a_version: assert property (p_version) else $error("version bytes wrong"); // RULE_05
  property p_no_unlock;
    (lock_q & ~$past(lock_q)) == 16'h0000;
  endproperty
  a_no_unlock: assert property (p_no_unlock) else $error("lock bit reopened"); // RULE_08
  property p_lock_rsvd;
    lock_q[6:4] == 3'h0;
  endproperty
  a_lock_rsvd: assert property (p_lock_rsvd) else $error("lock reserved bits set"); // RULE_07
  property p_xfer;
    s_set(hgr_pkg::ID_XFER) |=> tx_wide_q == $past(buf_q[0][0]) &&
      low_lat_q == $past(buf_q[1][1]) ##1 $stable(low_lat_q) || exec;
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer mode not stored"); // RULE_10
  property p_cfg;
    s_set(hgr_pkg::ID_CFG) |=> cfg_dyn_q && cfg_q.clk_hi == $past(buf_q[8]) &&
      cfg_q.dir == hgr_pkg::hgr_unpack($past({buf_q[0], buf_q[1]}));
  endproperty
  a_cfg: assert property (p_cfg) else $error("config not applied"); // RULE_16
  property p_special;
    sp_en[0] && sp_drv[0] |=> !pin_oe_n[0] && !pin_pull_up[0];
  endproperty
  a_special: assert property (p_special) else $error("clock pin not driven"); // RULE_17
endmodule // hgr_report_handler

//--- bench/hgr_pad_model.sv
`timescale 1ns/1ps
module hgr_pad_model (
  input wire logic pclk,
  input wire logic [hgr_pkg::NPIN-1:0] pin_out,
  input wire logic [hgr_pkg::NPIN-1:0] pin_oe_n,
  input wire logic [hgr_pkg::NPIN-1:0] pin_pull_up,
  input wire logic [hgr_pkg::NPIN-1:0] pin_pull_dn,
  output logic [hgr_pkg::NPIN-1:0] pin_level
);
  logic [hgr_pkg::NPIN-1:0] float_q = '0;
  // a pad nobody drives or pulls wanders every cycle
  always_ff @(posedge pclk) begin
    float_q <= ~pin_level;
  end
  always_comb begin
    for (int i = 0; i < hgr_pkg::NPIN; i++) begin
      if (!pin_oe_n[i]) pin_level[i] = pin_out[i];
      else if (pin_pull_up[i]) pin_level[i] = 1'b1;
      else if (pin_pull_dn[i]) pin_level[i] = 1'b0;
      else pin_level[i] = float_q[i];
    end
  end
endmodule // hgr_pad_model

//--- bench/test_hid_gpio_config_report_handler.sv
`timescale 1ns/1ps
module test_hid_gpio_config_report_handler;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // stored defaults: pins 6 and 7 push-pull outputs
  hgr_pkg::hgr_cfg_s stored_cfg = '{dir: 10'h0C0, push_pull: 10'h0C0, default: '0};
  // receive line high, all else low
  hgr_pkg::hgr_uart_s uart_in = 7'h02;
  logic usb_status_pin_one = 1'b1;
  logic usb_status_pin_two = 1'b0;
  logic [hgr_pkg::NPIN-1:0] pin_in, pin_out, pin_oe_n, pin_pull_up, pin_pull_dn;
  logic tx_wide, rx_wide, low_latency;
  logic [15:0] otp_lock;
  logic [31:0] rdata;
  logic rerr;
  logic cts_o;
  logic dsr_o;
  logic prev_lvl = 1'b0;
  int toggles = 0;
  int bad_count = 0;
  int checks_done = 0;

  always #12.5 pclk = ~pclk;

  hgr_report_handler DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stored_cfg(stored_cfg), .uart_in(uart_in),
    .usb_status_pin_one(usb_status_pin_one), .usb_status_pin_two(usb_status_pin_two),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up),
    .pin_pull_dn(pin_pull_dn), .pin2_clear_to_send(cts_o), .pin9_set_ready(dsr_o),
    .tx_wide(tx_wide), .rx_wide(rx_wide), .low_latency(low_latency), .otp_lock(otp_lock));

  hgr_pad_model pads (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pull_up(pin_pull_up), .pin_pull_dn(pin_pull_dn), .pin_level(pin_in));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready is tied high, so this wait ends after one cycle
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rep(input logic s, input logic [7:0] id, input logic [31:0] d0);
    if (s) apb(1'b1, hgr_pkg::ADDR_DATA0, d0);
    apb(1'b1, hgr_pkg::ADDR_CTRL, {23'h0, s, id});
    if (!s) apb(1'b0, hgr_pkg::ADDR_DATA0, 32'h0);
  endtask

  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  initial begin
    #100us;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk("mode", 3'b001, {tx_wide, rx_wide, low_latency});
    chk("lock", 16'hFF8F, otp_lock);
    chk("oe_n stored", 10'h33F, pin_oe_n);
    rep(1'b0, hgr_pkg::ID_VERSION, 0);
    chk("version", 16'h015A, rdata[15:0]);
    $display("reset and version done");
    rep(1'b1, hgr_pkg::ID_XFER, 32'h00000001);
    settle();
    chk("xfer1", 3'b100, {tx_wide, rx_wide, low_latency});
    rep(1'b0, hgr_pkg::ID_XFER, 0);
    chk("xfer get", 16'h0001, rdata[15:0]);
    rep(1'b1, hgr_pkg::ID_XFER, 32'h00000300);
    settle();
    chk("xfer2", 3'b011, {tx_wide, rx_wide, low_latency});
    $display("transfer mode done");
    rep(1'b1, hgr_pkg::ID_LOCK, 32'h00000FFF);
    settle();
    chk("lock set", 16'hFF0F, otp_lock);
    rep(1'b1, hgr_pkg::ID_LOCK, 32'h0000FFFF);
    rep(1'b0, hgr_pkg::ID_LOCK, 0);
    chk("lock sticky", 16'h0FFF, rdata[15:0]);
    $display("lock done");
    apb(1'b1, hgr_pkg::ADDR_DATA1, 32'h00300010);
    apb(1'b1, hgr_pkg::ADDR_DATA2, 32'h00000000);
    rep(1'b1, hgr_pkg::ID_CFG, 32'hFFFFCF0C);
    settle();
    chk("oe_n", 10'h300, pin_oe_n);
    chk("pull up", 10'h100, pin_pull_up);
    chk("pull dn", 10'h200, pin_pull_dn);
    rep(1'b0, hgr_pkg::ID_CFG, 0);
    chk("cfg get0", 32'hCF3CCF0C, rdata);
    apb(1'b0, hgr_pkg::ADDR_DATA1, 0);
    chk("cfg get1", 32'h00300010, rdata);
    $display("pin config done");
    rep(1'b1, hgr_pkg::ID_STATE_SET, 32'h0F10FFFF);
    settle();
    chk("state1", 10'h00F, pin_out);
    rep(1'b1, hgr_pkg::ID_STATE_SET, 32'h03000000);
    settle();
    chk("state2", 10'h00C, pin_out);
    rep(1'b0, hgr_pkg::ID_STATE_GET, 0);
    chk("live", 16'h2C50, rdata[15:0]);
    chk("cts dsr", 2'b10, {cts_o, dsr_o});
    $display("pin state done");
    rep(1'b0, hgr_pkg::ID_STATE_SET, 0);
    apb(1'b0, hgr_pkg::ADDR_CTRL, 0);
    chk("bad dir", 9'h145, {rdata[16], rdata[7:0]});
    apb(1'b0, 12'h010, 0);
    chk("unmapped err", 1'b1, rerr);
    chk("unmapped data", 32'h0, rdata);
    $display("refusals done");
    apb(1'b1, hgr_pkg::ADDR_DATA2, 32'h01000101);
    rep(1'b1, hgr_pkg::ID_CFG, 32'h00000600);
    settle();
    chk("od oe_n", 10'h3FC, pin_oe_n);
    prev_lvl = pin_out[0];
    repeat (50) begin
      @(posedge pclk);
      #1;
      if (pin_out[0] !== prev_lvl) toggles++;
      prev_lvl = pin_out[0];
    end
    // hi=lo=1: two edges per output period
    chk("clk edges", 50 * hgr_pkg::OUT_CLK_HZ / hgr_pkg::CORE_CLK_HZ, toggles);
    $display("clock output done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk("oe_n reset", 10'h33F, pin_oe_n);
    chk("mode reset", 3'b001, {tx_wide, rx_wide, low_latency});
    rep(1'b0, hgr_pkg::ID_CFG, 0);
    chk("cfg volatile", 32'h0, rdata);
    $display("second reset done");
    tally_and_finish();
  end
endmodule // test_hid_gpio_config_report_handler
